// ### design/otg_event_consts.vh
// register map, field positions and reset values of the otg event block
`ifndef OTG_EVENT_CONSTS_VH
`define OTG_EVENT_CONSTS_VH
`define OTG_CONTROL_WR 6'h0a
`define OTG_CONTROL_SET 6'h0b
`define OTG_CONTROL_CLR 6'h0c
`define RISE_EN_WR 6'h0d
`define RISE_EN_SET 6'h0e
`define RISE_EN_CLR 6'h0f
`define FALL_EN_WR 6'h10
`define FALL_EN_SET 6'h11
`define FALL_EN_CLR 6'h12
`define SRC_STATUS_ADDR 6'h13
`define EVT_LATCH_ADDR 6'h14
`define OTG_CONTROL_RST 8'h06
`define EDGE_EN_RST 8'h1f
`define SRC_MASK 8'h1f
`define CTRL_ID_PU_BIT 0
`define CTRL_DP_PD_BIT 1
`define CTRL_DM_PD_BIT 2
`define SRC_DETACH_BIT 0
`define SRC_SUPPLY_BIT 1
`define SRC_SESS_OK_BIT 2
`define SRC_SESS_OVER_BIT 3
`define SRC_IDENT_BIT 4
`endif

// ### design/otg_event_detect_regs.v
// otg control, edge enable masks, live status and event latch registers
`timescale 1ns/10ps
`default_nettype none
`include "otg_event_consts.vh"

// Notes on behaviour
// - dm pull-down follows bit 2, resets on
// - dp pull-down follows bit 1, resets on
// - bit 0 enables id pull-up and sampling
// - control read 0a-0c, write/set/clear there
// - enabled rising source edge raises event
// - enabled falling source edge raises event
// - rise mask bits four to zero, sources
// - fall mask uses same bit positions
// - both masks reset to all five enabled
// - rise mask read 0d-0f, write/set/clear
// - fall mask read 10-12, write/set/clear
// - status at 13 shows live sources
// - status bits four to zero, sources
// - latch at 14 cleared by read, lowpower
module otg_event_detect_regs #(
    parameter NSRC = 5
) (
    // clock and reset
    input wire clk,
    input wire arst_n,
    // register access from the ulpi front end
    input wire [5:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // raw detector levels, asynchronous
    input wire ident_grounded,
    input wire session_over,
    input wire session_ok_signal,
    input wire a_side_supply_ok,
    input wire downstream_detach_detect,
    // power state
    input wire low_power,
    // analog controls
    output wire minus_line_pd_en,
    output wire plus_line_pd_en,
    output wire ident_pin_pu_en,
    // event to rx command generator
    output reg event_pulse,
    output reg [7:0] event_status
);
    reg [7:0] ctrl_r;
    reg [7:0] ctrl_nxt;
    reg [7:0] rise_en_r;
    reg [7:0] rise_en_nxt;
    reg [7:0] fall_en_r;
    reg [7:0] fall_en_nxt;
    reg [7:0] latch_r;
    reg [7:0] latch_nxt;
    reg [7:0] prev_r;
    reg primed_r;
    wire [NSRC-1:0] raw_src;
    wire [NSRC-1:0] sync_src;
    wire [7:0] live;
    wire [7:0] rise_hit;
    wire [7:0] fall_hit;
    wire [7:0] hit;
    wire latch_rd;
    wire latch_clr;
    wire [1:0] ctrl_op;
    wire [1:0] rise_op;
    wire [1:0] fall_op;
    wire [7:0] rise_mask;
    wire [7:0] fall_mask;
    wire ident_grounded_rise_en;
    wire session_over_rise_en;
    wire session_ok_rise_en;
    wire supply_ok_rise_en;
    wire detach_rise_en;
    wire ident_grounded_fall_en;
    wire session_over_fall_en;
    wire session_ok_fall_en;
    wire supply_ok_fall_en;
    wire detach_fall_en;
    wire ident_sampled;
    wire [7:0] rise_seen;
    wire [7:0] fall_seen;
    wire any_hit;

    // operation codes of the write, set and clear addresses
    localparam [1:0] OP_KEEP = 2'd0;
    localparam [1:0] OP_WRITE = 2'd1;
    localparam [1:0] OP_SET = 2'd2;
    localparam [1:0] OP_CLEAR = 2'd3;

    // write, set or clear of one byte register
    function [7:0] wsc;
        input [7:0] cur;
        input [7:0] din;
        input [1:0] op;
        begin
            case (op)
                OP_WRITE: wsc = din;
                OP_SET: wsc = cur | din;
                OP_CLEAR: wsc = cur & ~din;
                default: wsc = cur;
            endcase
        end
    endfunction

    // op code for a register whose three addresses start at base
    function [1:0] opsel;
        input [5:0] addr;
        input [5:0] base;
        input wr;
        begin
            if (!wr)
                opsel = OP_KEEP;
            else if (addr == base)
                opsel = OP_WRITE;
            else if (addr == base + 6'h01)
                opsel = OP_SET;
            else if (addr == base + 6'h02)
                opsel = OP_CLEAR;
            else
                opsel = OP_KEEP;
        end
    endfunction

    // true when addr is one of the three addresses starting at base
    function in_span;
        input [5:0] addr;
        input [5:0] base;
        begin
            in_span = (addr >= base) && (addr <= base + 6'h02);
        end
    endfunction

    assign raw_src[`SRC_IDENT_BIT] = ident_grounded;
    assign raw_src[`SRC_SESS_OVER_BIT] = session_over;
    assign raw_src[`SRC_SESS_OK_BIT] = session_ok_signal;
    assign raw_src[`SRC_SUPPLY_BIT] = a_side_supply_ok;
    assign raw_src[`SRC_DETACH_BIT] = downstream_detach_detect;

    // detector levels are asynchronous, so two flops first
    src_sync #(
        .WIDTH(NSRC)
    ) u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .async_in(raw_src),
        .sync_out(sync_src)
    );

    // id level only counts while its sampler is enabled
    assign ident_sampled = sync_src[`SRC_IDENT_BIT] &
        ctrl_r[`CTRL_ID_PU_BIT];

    // live status byte; reserved bits read zero, nothing latched
    assign live[7:5] = 3'b000;
    assign live[`SRC_IDENT_BIT] = ident_sampled;
    assign live[`SRC_SESS_OVER_BIT] = sync_src[`SRC_SESS_OVER_BIT];
    assign live[`SRC_SESS_OK_BIT] = sync_src[`SRC_SESS_OK_BIT];
    assign live[`SRC_SUPPLY_BIT] = sync_src[`SRC_SUPPLY_BIT];
    assign live[`SRC_DETACH_BIT] = sync_src[`SRC_DETACH_BIT];

    // raw transitions against the value held one cycle ago
    assign rise_seen = live & ~prev_r;
    assign fall_seen = ~live & prev_r;

    // rising-edge enables, one per source
    assign ident_grounded_rise_en = rise_en_r[`SRC_IDENT_BIT];
    assign session_over_rise_en = rise_en_r[`SRC_SESS_OVER_BIT];
    assign session_ok_rise_en = rise_en_r[`SRC_SESS_OK_BIT];
    assign supply_ok_rise_en = rise_en_r[`SRC_SUPPLY_BIT];
    assign detach_rise_en = rise_en_r[`SRC_DETACH_BIT];

    // falling-edge enables share the rising-edge positions
    assign ident_grounded_fall_en = fall_en_r[`SRC_IDENT_BIT];
    assign session_over_fall_en = fall_en_r[`SRC_SESS_OVER_BIT];
    assign session_ok_fall_en = fall_en_r[`SRC_SESS_OK_BIT];
    assign supply_ok_fall_en = fall_en_r[`SRC_SUPPLY_BIT];
    assign detach_fall_en = fall_en_r[`SRC_DETACH_BIT];

    // reserved mask bits are stored but never gate an edge
    assign rise_mask = {3'b000, ident_grounded_rise_en, session_over_rise_en,
        session_ok_rise_en, supply_ok_rise_en, detach_rise_en};
    assign fall_mask = {3'b000, ident_grounded_fall_en, session_over_fall_en,
        session_ok_fall_en, supply_ok_fall_en, detach_fall_en};

    // no edges until one sampled value is held after reset
    assign rise_hit = rise_seen & rise_mask & {8{primed_r}};
    assign fall_hit = fall_seen & fall_mask & {8{primed_r}};
    assign hit = (rise_hit | fall_hit) & `SRC_MASK;
    assign any_hit = |hit;

    // latch clears on its own read or while in low power
    assign latch_rd = reg_rd && (reg_addr == `EVT_LATCH_ADDR);
    assign latch_clr = latch_rd || low_power;

    // operation on each register from the address decode
    assign ctrl_op = opsel(reg_addr, `OTG_CONTROL_WR, reg_wr);
    assign rise_op = opsel(reg_addr, `RISE_EN_WR, reg_wr);
    assign fall_op = opsel(reg_addr, `FALL_EN_WR, reg_wr);

    // analog controls straight from the control register
    assign minus_line_pd_en = ctrl_r[`CTRL_DM_PD_BIT];
    assign plus_line_pd_en = ctrl_r[`CTRL_DP_PD_BIT];
    assign ident_pin_pu_en = ctrl_r[`CTRL_ID_PU_BIT];

    // control register next value
    always @* begin
        ctrl_nxt = wsc(ctrl_r, reg_wdata, ctrl_op);
    end

    // rising-edge mask next value
    always @* begin
        rise_en_nxt = wsc(rise_en_r, reg_wdata, rise_op);
    end

    // falling-edge mask next value
    always @* begin
        fall_en_nxt = wsc(fall_en_r, reg_wdata, fall_op);
    end

    // new event wins over a read clear so none is lost
    always @* begin
        if (latch_clr)
            latch_nxt = hit;
        else
            latch_nxt = latch_r | hit;
    end

    // control register; pull-downs on and id sampler off from reset
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            ctrl_r <= `OTG_CONTROL_RST;
        else
            ctrl_r <= ctrl_nxt;
    end

    // rising-edge mask; every source enabled after reset
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            rise_en_r <= `EDGE_EN_RST;
        else
            rise_en_r <= rise_en_nxt;
    end

    // falling-edge mask; every source enabled after reset
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            fall_en_r <= `EDGE_EN_RST;
        else
            fall_en_r <= fall_en_nxt;
    end

    // event latch
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            latch_r <= 8'h00;
        else
            latch_r <= latch_nxt;
    end

    // previous live value; primed one edge after reset
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_r <= 8'h00;
            primed_r <= 1'b0;
        end else begin
            prev_r <= live;
            primed_r <= 1'b1;
        end
    end

    // event strobe for the rx command byte
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            event_pulse <= 1'b0;
        else
            event_pulse <= any_hit;
    end

    // live snapshot registered every cycle, on the same edge as the strobe
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            event_status <= 8'h00;
        else
            event_status <= live;
    end

    // read mux; unmapped addresses read zero
    always @* begin
        if (in_span(reg_addr, `OTG_CONTROL_WR))
            reg_rdata = ctrl_r;
        else if (in_span(reg_addr, `RISE_EN_WR))
            reg_rdata = rise_en_r;
        else if (in_span(reg_addr, `FALL_EN_WR))
            reg_rdata = fall_en_r;
        else if (reg_addr == `SRC_STATUS_ADDR)
            reg_rdata = live;
        else if (reg_addr == `EVT_LATCH_ADDR)
            reg_rdata = latch_r;
        else
            reg_rdata = 8'h00;
    end
endmodule
`default_nettype wire

// ### design/src_sync.v
// two-stage synchroniser for the detector inputs
`timescale 1ns/10ps
`default_nettype none
module src_sync #(
    parameter WIDTH = 5
) (
    // clock and reset
    input wire clk,
    input wire arst_n,
    // asynchronous levels in, synchronised levels out
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_r;

    // first stage only feeds the second stage
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_r <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule
`default_nettype wire

// ### verif/otg_event_detect_regs_checker.sv
// port assertions for the otg event register block
`timescale 1ns/10ps
`default_nettype none
module otg_event_checker (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // register bus
    input wire logic [5:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // pad controls
    input wire logic minus_line_pd_en,
    input wire logic plus_line_pd_en,
    input wire logic ident_pin_pu_en
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // a write followed one cycle later by the same address still on the bus
    sequence s_upd(a);
        reg_wr && reg_addr == a ##1 reg_addr == a;
    endsequence
    // pads must follow the stored control bits
    property p_dm;
        reg_addr == 6'h0a |-> minus_line_pd_en == reg_rdata[2];
    endproperty
    a_dm: assert property (p_dm) else $error("dm pad off");
    property p_dp;
        reg_addr == 6'h0a |-> plus_line_pd_en == reg_rdata[1];
    endproperty
    a_dp: assert property (p_dp) else $error("dp pad off");
    property p_id;
        reg_addr == 6'h0a |-> ident_pin_pu_en == reg_rdata[0];
    endproperty
    a_id: assert property (p_id) else $error("id pad off");
    property p_ctl;
        s_upd(6'h0a) |-> reg_rdata == $past(reg_wdata);
    endproperty
    a_ctl: assert property (p_ctl) else $error("ctrl write");
    property p_cset;
        s_upd(6'h0b) |-> reg_rdata == ($past(reg_rdata) | $past(reg_wdata));
    endproperty
    a_cset: assert property (p_cset) else $error("ctrl set");
    property p_rset;
        s_upd(6'h0e) |-> reg_rdata == ($past(reg_rdata) | $past(reg_wdata));
    endproperty
    a_rset: assert property (p_rset) else $error("rise set");
    property p_rclr;
        s_upd(6'h0f) |-> reg_rdata == ($past(reg_rdata) & ~$past(reg_wdata));
    endproperty
    a_rclr: assert property (p_rclr) else $error("rise clr");
    property p_fwr;
        s_upd(6'h10) |-> reg_rdata == $past(reg_wdata);
    endproperty
    a_fwr: assert property (p_fwr) else $error("fall write");
    // pads leave reset with both pull-downs on and the id sampler off
    property p_rst_pads;
        $rose(arst_n) |-> minus_line_pd_en && plus_line_pd_en &&
            !ident_pin_pu_en;
    endproperty
    a_rst_pads: assert property (p_rst_pads)
        else $error("pad reset");
endmodule
bind otg_event_detect_regs otg_event_checker i_chk (.clk(clk),
    .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .minus_line_pd_en(minus_line_pd_en), .plus_line_pd_en(plus_line_pd_en),
    .ident_pin_pu_en(ident_pin_pu_en));
`default_nettype wire

// ### verif/otg_event_detect_regs_tb.sv
// self-checking bench for the otg event register block
`timescale 1ns/10ps
`default_nettype none
module otg_event_detect_regs_tb;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [4:0] det = 5'h00;
    logic lp = 1'b0;
    logic [5:0] reg_addr;
    logic reg_wr, reg_rd, event_pulse, dm_pd, dp_pd, id_pu;
    logic [7:0] reg_wdata, reg_rdata, event_status;
    int mismatches = 0;
    int n_tests = 0;
    int cyc = 0;
    always #25 clk = ~clk;
    ulpi_link i_link (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));
    // low power is pulsed by the latch scenario
    otg_event_detect_regs i_dut (.clk(clk), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ident_grounded(det[4]),
        .session_over(det[3]), .session_ok_signal(det[2]),
        .a_side_supply_ok(det[1]), .downstream_detach_detect(det[0]),
        .low_power(lp), .minus_line_pd_en(dm_pd),
        .plus_line_pd_en(dp_pd), .ident_pin_pu_en(id_pu),
        .event_pulse(event_pulse), .event_status(event_status));
    task complete_run;
        if (mismatches == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s exp %h got %h", nm, exp, got);
        end
    endtask
    task rc(input logic [5:0] a, input logic [7:0] e);
        logic [7:0] v;
        i_link.rd(a, v);
        chk("reg", v, e);
    endtask
    // reset values, control write, set and clear
    task t_ctrl;
        rc(6'h0a, 8'h06);
        rc(6'h0d, 8'h1f);
        rc(6'h12, 8'h1f);
        rc(6'h13, 8'h00);
        rc(6'h20, 8'h00);
        i_link.wr(6'h0a, 8'h01);
        rc(6'h0c, 8'h01);
        chk("pads", {5'h0, dm_pd, dp_pd, id_pu}, 8'h01);
        i_link.wr(6'h0b, 8'h06);
        rc(6'h0b, 8'h07);
        i_link.wr(6'h0c, 8'h03);
        rc(6'h0a, 8'h04);
        chk("pads", {5'h0, dm_pd, dp_pd, id_pu}, 8'h04);
    endtask
    // both masks through write, set and clear, reserved bits too
    task t_mask;
        logic [5:0] a;
        for (int i = 0; i < 2; i++) begin
            a = i ? 6'h10 : 6'h0d;
            i_link.wr(a, 8'h00);
            i_link.wr(a + 6'h01, 8'he2);
            rc(a + 6'h02, 8'he2);
            i_link.wr(a + 6'h02, 8'hc2);
            rc(a, 8'h20);
        end
    endtask
    // one detector edge, pulse expected or not
    task ev(input int b, input logic v, input logic e);
        logic s;
        logic [7:0] st;
        s = 1'b0;
        st = 8'h00;
        @(posedge clk);
        #2 det[b] = v;
        repeat (6) begin
            @(posedge clk);
            #2 if (event_pulse === 1'b1) begin
                s = 1'b1;
                st = event_status;
            end
        end
        chk("pulse", {7'h0, s}, {7'h0, e});
        if (e) chk("evst", st, {3'h0, det});
        rc(6'h13, {3'h0, det});
    endtask
    // each source alone, rise then fall mask
    task t_event;
        logic [7:0] m;
        i_link.wr(6'h0b, 8'h01);
        for (int b = 0; b < 5; b++) begin
            m = 8'h01 << b;
            i_link.wr(6'h0d, m);
            i_link.wr(6'h10, 8'h00);
            ev(b, 1'b1, 1'b1);
            ev(b, 1'b0, 1'b0);
            i_link.wr(6'h0d, 8'h00);
            i_link.wr(6'h10, m);
            ev(b, 1'b1, 1'b0);
            ev(b, 1'b0, 1'b1);
        end
    endtask
    // latch read clear, low power clear, id sampler gating
    task t_latch;
        i_link.wr(6'h0d, 8'h02);
        rc(6'h14, 8'h1f);
        rc(6'h14, 8'h00);
        ev(1, 1'b1, 1'b1);
        rc(6'h14, 8'h02);
        ev(1, 1'b0, 1'b0);
        rc(6'h14, 8'h00);
        ev(1, 1'b1, 1'b1);
        @(posedge clk);
        #2 lp = 1'b1;
        @(posedge clk);
        #2 lp = 1'b0;
        rc(6'h14, 8'h00);
        i_link.wr(6'h0c, 8'h01);
        @(posedge clk);
        #2 det[4] = 1'b1;
        repeat (4) @(posedge clk);
        rc(6'h13, {4'h0, det[3:0]});
        i_link.wr(6'h0b, 8'h01);
        rc(6'h13, {3'h0, det});
        ev(4, 1'b0, 1'b1);
    endtask
    // reset in mid run restores every register
    task t_reset;
        @(posedge clk);
        #2 arst_n = 1'b0;
        det = 5'h00;
        @(posedge clk);
        #2 arst_n = 1'b1;
        chk("pads", {5'h0, dm_pd, dp_pd, id_pu}, 8'h06);
        rc(6'h0c, 8'h06);
        rc(6'h0f, 8'h1f);
        rc(6'h11, 8'h1f);
        rc(6'h13, 8'h00);
        rc(6'h14, 8'h00);
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            mismatches++;
            complete_run;
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        #2 arst_n = 1'b1;
        t_ctrl;
        t_mask;
        t_event;
        t_latch;
        t_reset;
        complete_run;
    end
endmodule
`default_nettype wire

// ### verif/ulpi_link.sv
// link side register master model
`timescale 1ns/10ps
`default_nettype none
module ulpi_link (
    input wire logic clk,
    input wire logic [7:0] reg_rdata,
    output logic [5:0] reg_addr = 6'h00,
    output logic reg_wr = 1'b0,
    output logic [7:0] reg_wdata = 8'h00,
    output logic reg_rd = 1'b0
);
    // base, set or clear write; address kept so it reads back
    task wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        #2 reg_addr = a;
        reg_wr = 1'b1;
        reg_wdata = d;
        @(posedge clk);
        #2 reg_wr = 1'b0;
    endtask
    // read data taken at the edge that samples the strobe
    task rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk);
        #2 reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        d = reg_rdata;
        #2 reg_rd = 1'b0;
    endtask
endmodule
`default_nettype wire
